// [tb/opaddr_req_model.sv]
// Decoder-side model that launches address requests.
// Assumes requests change just after a rising ref_clk edge.
`timescale 1ns/100ps
`default_nettype none

module opaddr_req_model (
  input  wire logic        ref_clk,
  output logic             req_valid,
  output logic [7:0]       req_mode,
  output logic [1:0]       req_size,
  output logic [15:0]      req_field,
  output logic [23:0]      req_next_pc,
  output logic [7:0]       data_segment_reg,
  output logic [1:0]       active_bank
);
  initial begin
    {req_valid, req_mode, req_size, req_field, req_next_pc, data_segment_reg, active_bank} = '0;
  end

  // Idle cycles carry fresh values so stale fields are never trusted
  task automatic issue(input logic v, logic [7:0] m, logic [1:0] s, logic [15:0] f, logic [23:0] pc,
                       logic [7:0] ds, logic [1:0] bk);
    @(posedge ref_clk);
    {req_valid, req_mode, req_size, req_field, req_next_pc, data_segment_reg, active_bank} <=
      {v, m, s, f, pc, ds, bk};
  endtask
endmodule // opaddr_req_model

`default_nettype wire

// [tb/operand_address_generation_tb_top.sv]
// Self-checking bench for the operand address generator.
// Assumes one 25 MHz clock and answers one cycle after each request.
`timescale 1ns/100ps
`default_nettype none

module operand_address_generation_tb_top;
  import opaddr_pkg::*;
  logic ref_clk, srst, ans_valid, sel_rf, sel_data, sel_sfr, imm_valid, target_valid, bcd_ok;
  logic req_valid;
  logic [7:0] req_mode, data_segment_reg, pm, pds;
  logic [1:0] req_size, active_bank, ps, pbk;
  logic [15:0] req_field, imm_value, pf;
  logic [23:0] req_next_pc, op_addr, op_addr_hi, target_addr, ppc;
  logic [2:0] bit_pos;
  logic [6:0] rf_bit_byte;
  logic pv = 1'b0;
  int error_cnt = 0;
  int n_checks = 0;

  opaddr_req_model i_dec (.ref_clk(ref_clk), .req_valid(req_valid), .req_mode(req_mode), .req_size(req_size),
    .req_field(req_field), .req_next_pc(req_next_pc), .data_segment_reg(data_segment_reg), .active_bank(active_bank));
  operand_address_generation i_dut (.ref_clk(ref_clk), .srst(srst), .req_valid(req_valid), .req_mode(req_mode),
    .req_size(req_size), .req_field(req_field), .req_next_pc(req_next_pc), .data_segment_reg(data_segment_reg),
    .active_bank(active_bank), .ans_valid(ans_valid), .sel_rf(sel_rf), .sel_data(sel_data), .sel_sfr(sel_sfr),
    .op_addr(op_addr), .op_addr_hi(op_addr_hi), .bit_pos(bit_pos), .rf_bit_byte(rf_bit_byte),
    .imm_value(imm_value), .imm_valid(imm_valid), .target_addr(target_addr), .target_valid(target_valid),
    .bcd_ok(bcd_ok));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic vfy(input logic [7:0] m, logic [1:0] s, logic [15:0] f, logic [23:0] pc, logic [7:0] ds,
                     logic [1:0] bk);
    logic [15:0] a, t;
    logic dir, bt, im, rl;
    dir = (m == 8'h01);
    bt = (m == 8'h02);
    im = (|m[5:2]) && $onehot(m);
    rl = (m == 8'h40) || (m == 8'h80);
    a = {5'h00, f[10:0]} & ((s != 2'h0) ? 16'hfffe : 16'hffff);
    chk("ans_valid", ans_valid, 1'b1);
    chk("sel_sfr", sel_sfr, (dir && f[10]) || (bt && f[9]));
    chk("sel_data", sel_data, (dir && !f[10]) || (bt && f[9:8] == 2'h1));
    chk("sel_rf", sel_rf, bt && f[9:8] == 2'h0);
    if (dir) chk("op_addr", op_addr, f[10] ? {8'h00, a} : {ds, 6'h00, a[9:0]});
    if (dir && !f[10]) chk("op_addr_hi", op_addr_hi, {ds, 6'h00, a[9:0]} + 24'h000002);
    if (bt && f[9]) chk("op_addr", op_addr, {8'h00, SFR_BASE + {10'h000, f[8:3]}});
    if (bt && f[9:8] == 2'h1) chk("op_addr", op_addr, {ds, BIT_DATA_BASE + {11'h000, f[7:3]}});
    if (bt) chk("bit_pos", {21'h000000, bit_pos}, {21'h000000, f[2:0]});
    if (bt && f[9:8] == 2'h0) chk("rf_bit_byte", {17'h00000, rf_bit_byte}, {17'h00000, bk, f[7:3]});
    t = (m == 8'h04) ? {{12{f[3]}}, f[3:0]} : (m == 8'h08) ? {11'h000, f[4:0]} :
        (m == 8'h10) ? {{8{f[7]}}, f[7:0]} : f;
    chk("imm_valid", imm_valid, im);
    if (im) chk("imm_value", {8'h00, imm_value}, {8'h00, t});
    t = {pc[15:1], 1'b0} + ((m == 8'h40) ? {{7{f[7]}}, f[7:0], 1'b0} : {f[14:0], 1'b0});
    chk("target_valid", target_valid, rl);
    if (rl) chk("target_addr", target_addr, {pc[23:16], t});
    if (rl) chk("target_even", target_addr[0], 1'b0);
    chk("bcd_ok", bcd_ok, f[7:4] <= 4'h9 && f[3:0] <= 4'h9);
  endtask

  // Checks the request taken at this edge while launching the next one
  task automatic step(input logic v, logic [7:0] m, logic [1:0] s, logic [15:0] f, logic [23:0] pc,
                      logic [7:0] ds, logic [1:0] bk);
    i_dec.issue(v, m, s, f, pc, ds, bk);
    #1;
    if (pv) vfy(pm, ps, pf, ppc, pds, pbk);
    else chk("ans_valid", ans_valid, 1'b0);
    {pv, pm, ps, pf, ppc, pds, pbk} = {v, m, s, f, pc, ds, bk};
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (2000) @(posedge ref_clk);
    error_cnt++;
    wrap_up();
  end

  initial begin
    logic [7:0] m;
    srst = 1'b1;
    void'($urandom(32'hd76cbedc));
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    #1;
    chk("op_addr", op_addr, 24'h000000);
    chk("target_addr", target_addr, 24'h000000);
    step(1, 8'h01, 2'h1, 16'h0200, 24'h0, 8'h02, 2'h0);
    step(1, 8'h01, 2'h2, 16'h03ff, 24'h0, 8'hff, 2'h1);
    step(1, 8'h01, 2'h1, 16'h07ff, 24'h0, 8'h55, 2'h0);
    step(1, 8'h40, 2'h0, 16'h00ff, 24'h001235, 8'h0, 2'h0);
    step(1, 8'h40, 2'h0, 16'h007f, 24'h120001, 8'h0, 2'h0);
    step(1, 8'h80, 2'h0, 16'h8000, 24'h34ffff, 8'h0, 2'h0);
    step(1, 8'h80, 2'h0, 16'h7fff, 24'h000002, 8'h0, 2'h0);
    step(1, 8'h02, 2'h0, 16'h0308, 24'h0, 8'h07, 2'h0);
    step(1, 8'h02, 2'h0, 16'h01ff, 24'h0, 8'h9a, 2'h2);
    step(1, 8'h02, 2'h0, 16'h00ff, 24'h0, 8'h00, 2'h3);
    step(1, 8'h04, 2'h0, 16'h0008, 24'h0, 8'h0, 2'h0);
    step(1, 8'h08, 2'h0, 16'h001f, 24'h0, 8'h0, 2'h0);
    step(1, 8'h10, 2'h0, 16'h0080, 24'h0, 8'h0, 2'h0);
    step(1, 8'h20, 2'h0, 16'h9a99, 24'h0, 8'h0, 2'h0);
    step(1, 8'h03, 2'h1, 16'h0499, 24'h0, 8'h0, 2'h0);
    repeat (200) begin
      m = 8'h01 << ($urandom % 8);
      step(($urandom % 4) != 0, m, 2'($urandom % 3), 16'($urandom), 24'($urandom), 8'($urandom), 2'($urandom));
    end
    step(0, 8'h00, 2'h0, 16'h0, 24'h0, 8'h0, 2'h0);
    step(0, 8'h00, 2'h0, 16'h0, 24'h0, 8'h0, 2'h0);
    wrap_up();
  end
endmodule // operand_address_generation_tb_top

`default_nettype wire

// [verilog/opaddr_pkg.sv]
// Constants for the operand and branch-target address generator.
// Assumes a 16-bit core with 24-bit addresses, one clock, sync reset.
// Contract
// - Direct address is a 10-bit field reaching only the lowest 1K of segment.
// - Direct data upper byte comes from data segment, never extra segment.
// - Field values 400h to 7FFh select the peripheral register space.
// - Peripheral addresses steer to their own path, never data memory.
// - Peripheral accesses use low 16 bits only; data prepends segment byte.
// - Immediates are 4, 5, 8 or 16-bit constants from the instruction.
// - Add-short and move-short 4-bit immediates are sign extended.
// - Bit address 0-FFh register file, 100h-1FFh data, 200h-3FFh peripheral.
// - The 256 register file bits cover the active register bank.
// - Data bit addresses reach bytes 20h to 3Fh of the current segment.
// - Peripheral bit addresses reach bytes 400h to 43Fh.
// - Jump, call and branch targets are always even.
// - Short displacement is 8 bits of words doubled to a 9-bit offset.
// - Long displacement is 16 bits of words doubled to a 17-bit offset.
// - Relative base is the address of the following instruction.
// - Odd base is forced to the next lower even address first.
// - Effective address is 24 bits: 8-bit segment plus 16-bit address.
// - Words are two contiguous bytes, double words two contiguous words.
// - Signed operands are two's complement in arithmetic and extension.
// - Decimal operands are bytes holding two packed digits.
// - Odd word operand addresses have bit 0 cleared.
package opaddr_pkg;

  // ************************************************************
  // Request modes, one-hot
  // ************************************************************
  typedef enum logic [7:0] {
    MODE_DIRECT = 8'h01,
    MODE_BIT    = 8'h02,
    MODE_IMM4   = 8'h04,
    MODE_IMM5   = 8'h08,
    MODE_IMM8   = 8'h10,
    MODE_IMM16  = 8'h20,
    MODE_SHORT_WORD_DISPLACEMENT   = 8'h40,
    MODE_LONG_WORD_DISPLACEMENT  = 8'h80
  } mode_e;

  // ************************************************************
  // Operand sizes
  // ************************************************************
  localparam logic [1:0] SIZE_BYTE  = 2'h0;
  localparam logic [1:0] SIZE_WORD  = 2'h1;
  localparam logic [1:0] SIZE_DWORD = 2'h2;

  // ************************************************************
  // Field positions and bases
  // ************************************************************
  localparam int          SFR_SEL_BIT    = 10;
  localparam int          BIT_SPACE_MSB  = 9;
  localparam int          BIT_DATA_SEL   = 8;
  localparam logic [15:0] BIT_DATA_BASE  = 16'h0020;
  localparam logic [15:0] SFR_BASE       = 16'h0400;
  localparam logic [15:0] WORD_STRIDE    = 16'h0002;
  localparam logic [7:0]  SFR_SEGMENT    = 8'h00;
  localparam logic [3:0]  BCD_MAX_DIGIT  = 4'h9;
  localparam logic [23:0] ADDR_RESET     = 24'h000000;
  localparam logic [15:0] IMM_RESET      = 16'h0000;
  localparam int          DECODE_CYCLES  = 1;

endpackage

// [verilog/operand_address_generation.sv]
// Operand, bit and branch-target address generation.
// Assumes decoder inputs on ref_clk; answer one cycle after req_valid.
`timescale 1ns/100ps
`default_nettype none

module operand_address_generation
  import opaddr_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        req_valid,
  input  wire logic [7:0]  req_mode,
  input  wire logic [1:0]  req_size,
  input  wire logic [15:0] req_field,
  input  wire logic [23:0] req_next_pc,
  input  wire logic [7:0]  data_segment_reg,
  input  wire logic [1:0]  active_bank,
  output logic             ans_valid,
  output logic             sel_rf,
  output logic             sel_data,
  output logic             sel_sfr,
  output logic [23:0]      op_addr,
  output logic [23:0]      op_addr_hi,
  output logic [2:0]       bit_pos,
  output logic [6:0]       rf_bit_byte,
  output logic [15:0]      imm_value,
  output logic             imm_valid,
  output logic [23:0]      target_addr,
  output logic             target_valid,
  output logic             bcd_ok
);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [15:0] sext4(input logic [3:0] v);
    sext4 = {{12{v[3]}}, v};
  endfunction

  function automatic logic [15:0] clr_bit0(input logic [15:0] v);
    clr_bit0 = {v[15:1], 1'b0};
  endfunction

  // ************************************************************
  // Decode
  // ************************************************************
  wire logic is_direct = req_mode == MODE_DIRECT;
  wire logic is_bit    = req_mode == MODE_BIT;
  wire logic is_imm    = (req_mode == MODE_IMM4) || (req_mode == MODE_IMM5) ||
                         (req_mode == MODE_IMM8) || (req_mode == MODE_IMM16);
  wire logic is_rel    = (req_mode == MODE_SHORT_WORD_DISPLACEMENT) || (req_mode == MODE_LONG_WORD_DISPLACEMENT);
  wire logic wide      = req_size != SIZE_BYTE;

  // Direct field bit 10 splits RAM from peripheral space
  wire logic [9:0] dir_low   = req_field[9:0];
  wire logic       dir_sfr   = req_field[SFR_SEL_BIT];
  wire logic [15:0] dir_raw  = {6'h00, dir_low};
  wire logic [15:0] sfr_raw  = SFR_BASE | dir_raw;
  wire logic [15:0] dir_even = wide ? clr_bit0(dir_raw) : dir_raw;
  wire logic [15:0] sfr_even = wide ? clr_bit0(sfr_raw) : sfr_raw;

  // Bit addressing spaces
  wire logic [9:0]  bit_field = req_field[BIT_SPACE_MSB:0];
  wire logic        bit_sfr   = bit_field[BIT_SPACE_MSB];
  wire logic        bit_data  = !bit_sfr && bit_field[BIT_DATA_SEL];
  wire logic        bit_rf    = !bit_sfr && !bit_field[BIT_DATA_SEL];
  wire logic [15:0] bit_dbyte = BIT_DATA_BASE | {11'h000, bit_field[7:3]};
  wire logic [15:0] bit_sbyte = SFR_BASE | {10'h000, bit_field[8:3]};

  // Path select: at most one path, memory modes exactly one
  wire logic n_rf   = is_bit && bit_rf;
  wire logic n_sfr  = (is_direct && dir_sfr) || (is_bit && bit_sfr);
  wire logic n_data = (is_direct && !dir_sfr) || (is_bit && bit_data);

  // Segment byte only on the data path
  wire logic [7:0]  seg_byte = n_data ? data_segment_reg : SFR_SEGMENT;
  wire logic [15:0] low_addr = is_bit ? (bit_sfr ? bit_sbyte : bit_dbyte) :
                               (dir_sfr ? sfr_even : dir_even);
  wire logic [23:0] n_addr   = {seg_byte, low_addr};
  // Upper word of a double word sits two bytes on, same segment
  wire logic [15:0] hi_low   = low_addr + WORD_STRIDE;
  wire logic [23:0] n_addr_hi = {seg_byte, hi_low};

  // Immediates
  wire logic [15:0] n_imm =
    (req_mode == MODE_IMM4) ? sext4(req_field[3:0]) :
    (req_mode == MODE_IMM5) ? {11'h000, req_field[4:0]} :
    (req_mode == MODE_IMM8) ? {{8{req_field[7]}}, req_field[7:0]} :
    req_field;

  // Two packed digits in the low byte
  wire logic n_bcd = (req_field[3:0] <= BCD_MAX_DIGIT) &&
                     (req_field[7:4] <= BCD_MAX_DIGIT);

  // Relative target: even base plus doubled word displacement
  wire logic [15:0] base_even = clr_bit0(req_next_pc[15:0]);
  wire logic [8:0]  off9  = {req_field[7:0], 1'b0};
  wire logic [16:0] off17 = {req_field, 1'b0};
  wire logic [15:0] disp  = (req_mode == MODE_SHORT_WORD_DISPLACEMENT) ?
                            {{7{off9[8]}}, off9} : off17[15:0];
  wire logic [15:0] tgt_low = base_even + disp;
  wire logic [23:0] n_target = {req_next_pc[23:16], tgt_low[15:1], 1'b0};

  // ************************************************************
  // Answer registers
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ans_valid    <= 1'b0;
      sel_rf       <= 1'b0;
      sel_data     <= 1'b0;
      sel_sfr      <= 1'b0;
      imm_valid    <= 1'b0;
      target_valid <= 1'b0;
    end else begin
      ans_valid    <= req_valid;
      sel_rf       <= req_valid && n_rf;
      sel_data     <= req_valid && n_data;
      sel_sfr      <= req_valid && n_sfr;
      imm_valid    <= req_valid && is_imm;
      target_valid <= req_valid && is_rel;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      op_addr     <= ADDR_RESET;
      op_addr_hi  <= ADDR_RESET;
      bit_pos     <= 3'h0;
      rf_bit_byte <= 7'h00;
      imm_value   <= IMM_RESET;
      target_addr <= ADDR_RESET;
      bcd_ok      <= 1'b0;
    end else if (req_valid) begin
      op_addr     <= n_addr;
      op_addr_hi  <= n_addr_hi;
      bit_pos     <= bit_field[2:0];
      rf_bit_byte <= {active_bank, bit_field[7:3]};
      imm_value   <= n_imm;
      target_addr <= n_target;
      bcd_ok      <= n_bcd;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  one_path_a: assert property (@(posedge ref_clk) disable iff (srst)
    ans_valid |-> $onehot0({sel_rf, sel_data, sel_sfr}))
    else $error("more than one access path selected");

  one_cycle_a: assert property (@(posedge ref_clk) disable iff (srst)
    req_valid && (is_direct || is_bit) |=> (sel_rf || sel_data || sel_sfr))
    else $error("memory access not steered in one cycle");

  direct_seg_a: assert property (@(posedge ref_clk) disable iff (srst)
    req_valid && is_direct && !req_field[10] |=>
      sel_data && op_addr[23:16] == $past(data_segment_reg) && op_addr[15:10] == 6'h00)
    else $error("direct data address wrong segment or range");

  sfr_space_a: assert property (@(posedge ref_clk) disable iff (srst)
    req_valid && is_direct && req_field[10] |=>
      sel_sfr && op_addr[23:11] == 13'h0000 && op_addr[10])
    else $error("peripheral address not in 400h-7FFh");

  bit_data_a: assert property (@(posedge ref_clk) disable iff (srst)
    req_valid && is_bit && req_field[9:8] == 2'h1 |=>
      sel_data && op_addr[15:0] >= 16'h0020 && op_addr[15:0] <= 16'h003f)
    else $error("data bit byte out of 20h-3Fh");

  bit_sfr_a: assert property (@(posedge ref_clk) disable iff (srst)
    req_valid && is_bit && req_field[9] |=>
      sel_sfr && op_addr[15:0] >= 16'h0400 && op_addr[15:0] <= 16'h043f)
    else $error("peripheral bit byte out of 400h-43Fh");

  word_even_a: assert property (@(posedge ref_clk) disable iff (srst)
    req_valid && is_direct && req_size != SIZE_BYTE |=> !op_addr[0])
    else $error("word operand address odd");

  short_sext_a: assert property (@(posedge ref_clk) disable iff (srst)
    req_valid && req_mode == MODE_IMM4 |=>
      imm_valid && imm_value[15:3] == {13{$past(req_field[3])}})
    else $error("short immediate not sign extended");

  target_even_a: assert property (@(posedge ref_clk) disable iff (srst)
    target_valid |-> !target_addr[0])
    else $error("branch target odd");

  short_word_displacement_calc_a: assert property (@(posedge ref_clk) disable iff (srst)
    req_valid && req_mode == MODE_SHORT_WORD_DISPLACEMENT |=> target_addr[15:0] ==
      16'(({$past(req_next_pc[15:1]), 1'b0}) + {{7{$past(req_field[7])}}, $past(req_field[7:0]), 1'b0}))
    else $error("short branch target wrong");

  long_word_displacement_calc_a: assert property (@(posedge ref_clk) disable iff (srst)
    req_valid && req_mode == MODE_LONG_WORD_DISPLACEMENT |=> target_addr[15:0] ==
      16'({$past(req_next_pc[15:1]), 1'b0} + {$past(req_field[14:0]), 1'b0}))
    else $error("long branch target wrong");

  target_seg_a: assert property (@(posedge ref_clk) disable iff (srst)
    req_valid && is_rel |=>
      target_valid && target_addr[23:16] == $past(req_next_pc[23:16]))
    else $error("branch target left the code page of the next pc");

  // Zero displacement shows the forced even base directly
  base_even_a: assert property (@(posedge ref_clk) disable iff (srst)
    req_valid && req_mode == MODE_SHORT_WORD_DISPLACEMENT && req_field[7:0] == 8'h00 |=>
      target_addr[15:0] == {$past(req_next_pc[15:1]), 1'b0})
    else $error("odd branch base not forced even");

  rel_flag_a: assert property (@(posedge ref_clk) disable iff (srst)
    req_valid && is_rel |=>
      target_valid && !imm_valid && !sel_rf && !sel_data && !sel_sfr)
    else $error("branch request raised a wrong flag");

  // ************************************************************
  // Immediate checks
  // ************************************************************
  imm_flag_a: assert property (@(posedge ref_clk) disable iff (srst)
    req_valid && is_imm |=> imm_valid && !target_valid)
    else $error("immediate request not flagged");

  imm5_zext_a: assert property (@(posedge ref_clk) disable iff (srst)
    req_valid && req_mode == MODE_IMM5 |=>
      imm_value == {11'h000, $past(req_field[4:0])})
    else $error("5-bit immediate not zero extended");

  imm8_sext_a: assert property (@(posedge ref_clk) disable iff (srst)
    req_valid && req_mode == MODE_IMM8 |=>
      imm_value == {{8{$past(req_field[7])}}, $past(req_field[7:0])})
    else $error("8-bit immediate not sign extended");

  imm16_pass_a: assert property (@(posedge ref_clk) disable iff (srst)
    req_valid && req_mode == MODE_IMM16 |=> imm_value == $past(req_field))
    else $error("16-bit immediate altered");

  bcd_flag_a: assert property (@(posedge ref_clk) disable iff (srst)
    req_valid |=> bcd_ok == ($past(req_field[3:0]) <= BCD_MAX_DIGIT &&
      $past(req_field[7:4]) <= BCD_MAX_DIGIT))
    else $error("packed digit flag wrong");

  // ************************************************************
  // Space and bit checks
  // ************************************************************
  direct_range_a: assert property (@(posedge ref_clk) disable iff (srst)
    req_valid && is_direct |=> op_addr[15:11] == 5'h00)
    else $error("direct address above 7FFh");

  sfr_no_seg_a: assert property (@(posedge ref_clk) disable iff (srst)
    sel_sfr |-> op_addr[23:16] == SFR_SEGMENT)
    else $error("peripheral access carries a segment byte");

  // High word must not carry into the segment byte
  dword_hi_a: assert property (@(posedge ref_clk) disable iff (srst)
    req_valid && is_direct && !req_field[10] |=>
      op_addr_hi == {op_addr[23:16], 16'(op_addr[15:0] + WORD_STRIDE)})
    else $error("second word address wrong");

  bit_rf_a: assert property (@(posedge ref_clk) disable iff (srst)
    req_valid && is_bit && req_field[9:8] == 2'h0 |=>
      sel_rf && rf_bit_byte == {$past(active_bank), $past(req_field[7:3])})
    else $error("register file bit not in active bank");

  bit_pos_a: assert property (@(posedge ref_clk) disable iff (srst)
    req_valid && is_bit |=> bit_pos == $past(req_field[2:0]))
    else $error("bit position wrong");

  // ************************************************************
  // Reset, idle and hold checks
  // ************************************************************
  reset_clear_a: assert property (@(posedge ref_clk)
    srst |=> !ans_valid && op_addr == ADDR_RESET && target_addr == ADDR_RESET &&
      imm_value == IMM_RESET && !bcd_ok)
    else $error("outputs not cleared by reset");

  idle_flags_a: assert property (@(posedge ref_clk) disable iff (srst)
    !req_valid |=> !ans_valid && !sel_rf && !sel_data && !sel_sfr &&
      !imm_valid && !target_valid)
    else $error("flag raised without a request");

  // Consumers may read data late, so it must hold between requests
  hold_data_a: assert property (@(posedge ref_clk) disable iff (srst)
    !req_valid |=> $stable(op_addr) && $stable(imm_value) && $stable(target_addr))
    else $error("data output changed without a request");

  odd_mode_a: assert property (@(posedge ref_clk) disable iff (srst)
    req_valid && !$onehot(req_mode) |=> ans_valid && !sel_rf && !sel_data &&
      !sel_sfr && !imm_valid && !target_valid)
    else $error("undefined mode raised a path flag");

endmodule // operand_address_generation

`default_nettype wire
